/* File: cmb_pkg.sv */
// Command engine constants
package cmb_pkg;

  // Clock and execution timing
  localparam int CMB_CLK_PERIOD_NS = 50;
  localparam int CMB_EXEC_TIME_NS = 1000;
  localparam int CMB_EXEC_CYCLES = (CMB_EXEC_TIME_NS + CMB_CLK_PERIOD_NS - 1) / CMB_CLK_PERIOD_NS;
  localparam logic [4:0] CMB_EXEC_LOAD = 5'(CMB_EXEC_CYCLES - 1);

  // Capability defaults
  localparam int CMB_NUM_INST = 2;
  localparam logic CMB_BACKGROUND = 1'b1;

  // AXI4-Lite geometry and answers
  localparam int CMB_AW = 12;
  localparam logic [1:0] CMB_RESP_OKAY = 2'b00;
  localparam logic [1:0] CMB_RESP_SLVERR = 2'b10;

  // Control register byte addresses
  localparam logic [11:0] CMB_ADDR_PAGE_BANK = 12'h000;
  localparam logic [11:0] CMB_ADDR_FLAGS = 12'h004;
  localparam logic [11:0] CMB_ADDR_MASK = 12'h008;
  localparam logic [11:0] CMB_ADDR_STATUS0 = 12'h00c;
  localparam logic [11:0] CMB_ADDR_STATUS1 = 12'h010;
  localparam logic [11:0] CMB_ADDR_ADVERT = 12'h014;
  localparam logic [11:0] CMB_ADDR_PRIV = 12'h018;
  localparam int CMB_WIN_BIT = 10;
  localparam int CMB_BANK_BIT = 8;

  // Paged memory layout
  localparam logic [7:0] CMB_PAGE_CMD = 8'h9f;
  localparam logic [7:0] CMB_PAGE_EPL_FIRST = 8'ha0;
  localparam logic [7:0] CMB_PAGE_EPL_LAST = 8'haf;
  localparam logic [4:0] CMB_CMD_WORD = 5'h00;
  localparam logic [4:0] CMB_OPERAND_WORD = 5'h01;
  localparam logic [4:0] CMB_LPL_LAST_WORD = 5'h1e;
  localparam logic [4:0] CMB_RSP_WORD = 5'h1f;
  localparam logic [7:0] CMB_LPL_MAX_BYTES = 8'h78;
  localparam logic [7:0] CMB_OPERAND_BYTES = 8'h04;
  localparam int CMB_EPL_WORDS = 512;

  // Completion flag positions in the flag byte
  localparam int CMB_FLAG_LSB = 6;

  // Advertisement byte fields
  localparam int CMB_ADV_INST_LSB = 6;
  localparam int CMB_ADV_BG_BIT = 5;
  localparam logic [1:0] CMB_ADV_ONE = 2'b01;
  localparam logic [1:0] CMB_ADV_TWO = 2'b10;

  // Command codes
  localparam logic [15:0] CMB_CMD_NOP = 16'h0000;
  localparam logic [15:0] CMB_CMD_ECHO = 16'h0001;
  localparam logic [15:0] CMB_CMD_ABORT = 16'h0004;

  // Status byte values, bit 7 is the busy flag
  localparam logic [7:0] CMB_STS_IDLE = 8'h00;
  localparam logic [7:0] CMB_COMMAND_BUSY_FLAG = 8'h81;
  localparam logic [7:0] CMB_STS_OK = 8'h01;
  localparam logic [7:0] CMB_STS_ERR_UNKNOWN = 8'h42;
  localparam logic [7:0] CMB_STS_ERR_PRIV = 8'h43;
  localparam logic [7:0] CMB_STS_ERR_PARAM = 8'h44;
  localparam logic [7:0] CMB_STS_ERR_CHECK = 8'h45;
  localparam logic [7:0] CMB_STS_ABORTED = 8'h46;
  localparam logic [7:0] CMB_STS_ERR_EXEC = 8'h47;

  // Engine states
  typedef enum logic [2:0] {
    CMB_ST_IDLE = 3'b000,
    CMB_ST_CAPTURE = 3'b001,
    CMB_ST_CHECK = 3'b010,
    CMB_ST_VALID = 3'b011,
    CMB_ST_EXEC = 3'b100,
    CMB_ST_DONE = 3'b101
  } cmb_state_e;

endpackage

/* File: cmb_engine.sv */
// One command message instance: capture, check, validate, execute, report
`timescale 1ns/10ps
module cmb_engine (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic rst_n,
  input wire logic ce,
  // Requests
  input wire logic start,
  input wire logic abort,
  input wire logic priv,
  input wire logic [31:0] cmd,
  input wire logic [31:0] operand,
  // Results
  output logic busy,
  output logic capturing,
  output logic done,
  output logic [7:0] status,
  output logic [31:0] rsp
);
  import cmb_pkg::*;

  cmb_state_e state; // Sequencer state
  logic [31:0] cmd_q; // Captured command word
  logic [31:0] op_q; // Captured first payload word
  logic [4:0] cnt; // Execution countdown
  logic [7:0] sum; // Check code sum over header
  logic known; // Code is one we execute

  assign busy = (state != CMB_ST_IDLE);
  assign capturing = (state == CMB_ST_CAPTURE);
  assign sum = cmd_q[15:8] + cmd_q[7:0] + cmd_q[23:16];
  assign known = (cmd_q[15:0] == CMB_CMD_NOP) || (cmd_q[15:0] == CMB_CMD_ECHO) ||
                 (cmd_q[15:0] == CMB_CMD_ABORT);

  // Command sequencer; abort wins over every busy step except DONE
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      state <= CMB_ST_IDLE;
      cmd_q <= 32'h0000_0000;
      op_q <= 32'h0000_0000;
      cnt <= 5'h00;
      status <= CMB_STS_IDLE;
      rsp <= 32'h0000_0000;
    end else if (ce) begin
      if (abort && busy && state != CMB_ST_DONE) begin
        status <= CMB_STS_ABORTED; // RULE_22
        state <= CMB_ST_DONE;
      end else begin
        case (state)
          CMB_ST_IDLE: begin
            if (start) begin
              cmd_q <= cmd; // RULE_06
              op_q <= operand;
              status <= CMB_COMMAND_BUSY_FLAG; // RULE_21
              state <= CMB_ST_CAPTURE;
            end
          end
          CMB_ST_CAPTURE: begin
            state <= CMB_ST_CHECK;
          end
          CMB_ST_CHECK: begin
            // Check byte: inverted sum of code and length
            if (cmd_q[31:24] != ~sum) begin
              status <= CMB_STS_ERR_CHECK; // RULE_06
              state <= CMB_ST_DONE;
            end else begin
              state <= CMB_ST_VALID;
            end
          end
          CMB_ST_VALID: begin
            if (!known) begin
              status <= CMB_STS_ERR_UNKNOWN; // RULE_07
              state <= CMB_ST_DONE;
            end else if (cmd_q[23:16] > CMB_LPL_MAX_BYTES) begin
              status <= CMB_STS_ERR_PARAM; // RULE_06
              state <= CMB_ST_DONE;
            end else if (!priv && cmd_q[15:0] != CMB_CMD_ABORT) begin
              status <= CMB_STS_ERR_PRIV; // RULE_06
              state <= CMB_ST_DONE;
            end else begin
              cnt <= CMB_EXEC_LOAD; // RULE_07
              state <= CMB_ST_EXEC;
            end
          end
          CMB_ST_EXEC: begin
            if (cnt == 5'h00) begin
              // Echo needs one whole operand word, else an execution error
              if (cmd_q[15:0] == CMB_CMD_ECHO && cmd_q[23:16] < CMB_OPERAND_BYTES) begin
                status <= CMB_STS_ERR_EXEC; // RULE_07
                rsp <= 32'h0000_0000;
              end else begin
                status <= CMB_STS_OK; // RULE_08
                rsp <= (cmd_q[15:0] == CMB_CMD_ECHO) ? op_q : 32'h0000_0000;
              end
              state <= CMB_ST_DONE;
            end else begin
              cnt <= cnt - 5'h01;
            end
          end
          CMB_ST_DONE: begin
            state <= CMB_ST_IDLE; // RULE_09
          end
          default: begin
            state <= CMB_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Completion pulse after final status
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= (state == CMB_ST_DONE); // RULE_08
    end
  end

endmodule // cmb_engine

/* File: cmb_top.sv */
// Command engine with AXI4-Lite paged memory view
// Operation
// RULE_01: Command traffic lives in pages 9Fh to AFh
// RULE_02: Page 9Fh holds code and 120-byte payload
// RULE_03: Pages A0h-AFh hold 2048-byte extended payload
// RULE_04: Status bytes 37 and 38 always readable; here refused while an instance captures, or for the whole run in foreground
// RULE_05: Completion sets maskable flag in byte 8
// RULE_06: Capture, check code, validate code, privilege
// RULE_07: Report error or execute, then check result
// RULE_08: Finish: response, status, completion bit, interrupt
// RULE_09: Every command yields a response
// RULE_10: Background refuses until captured, foreground until done
// RULE_11: One or two instances as advertised
// RULE_12: Two background instances run alongside register access
// RULE_13: Foreground runs one command, either bank
// RULE_14: Instance one in bank 0, two in bank 1
// RULE_15: Foreground-only advertises bit 5 zero
// RULE_16: Foreground refuses every access while executing
// RULE_17: Foreground completion updates status, then accepts again
// RULE_18: Host retries refused accesses
// RULE_19: Host recovers a stuck module by reset pin
// RULE_20: Single background instance advertises 01b and 1b
// RULE_21: Busy shown by status bit 7
// RULE_22: Only abort accepted while busy; it ends command
// RULE_23: Busy instance rejects commands, protects its memory
// RULE_24: Interrupt low while any unmasked completion flag
`timescale 1ns/10ps
module cmb_top #(
  parameter int NUM_INST = cmb_pkg::CMB_NUM_INST,
  parameter logic BACKGROUND = cmb_pkg::CMB_BACKGROUND
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [cmb_pkg::CMB_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [cmb_pkg::CMB_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Module pins
  input wire logic module_reset_n,
  output logic module_interrupt_n
);
  import cmb_pkg::*;

  // Reset pin synchroniser and combined reset
  logic mrst_meta; // First stage, read only by second stage
  logic mrst_sync; // Synchronised reset pin level
  logic rst_n; // Combined active-low reset

  // Software-visible control state
  logic [7:0] page_sel; // Selected page
  logic bank_sel; // Selected bank
  logic [1:0] flags; // Sticky completion flags
  logic [1:0] mask; // Completion flag masks
  logic priv; // Privilege for non-abort commands

  // Paged storage, flip-flops
  logic [31:0] local_payload_area [0:1][0:31]; // Per bank command word and local payload
  logic [31:0] extended_payload_area [0:CMB_EPL_WORDS-1]; // Shared extended payload

  // Engine results
  logic [1:0] busy;
  logic [1:0] capturing;
  logic [1:0] done;
  logic [7:0] status [0:1];
  logic [31:0] rsp [0:1];
  logic [1:0] start;
  logic [1:0] abort;

  // Bus capture registers
  logic [CMB_AW-1:0] aw_q;
  logic [CMB_AW-1:0] ar_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Decode
  logic nack; // Access refused for engine activity
  logic wr_go; // Both write halves held, no answer pending
  logic rd_go; // Read address held, no answer pending
  logic bank_ok; // Selected bank has an instance
  logic [4:0] wr_word;
  logic [4:0] rd_word;
  logic wr_cmd_pg;
  logic wr_epl_pg;
  logic lpl_wr_c;
  logic cmd_wr_c;
  logic abort_c;
  logic epl_wr_c;
  logic ctrl_wr_c;
  logic wr_ok;
  logic [31:0] lpl_old;
  logic [31:0] wr_merged;
  logic [8:0] epl_wr_idx;
  logic [8:0] epl_rd_idx;
  logic [1:0] flag_clr;
  logic [31:0] next_rdata;
  logic next_rd_ok;
  logic [7:0] advert;

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reset pin through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mrst_meta <= 1'b1;
      mrst_sync <= 1'b1;
    end else if (ce) begin
      mrst_meta <= module_reset_n;
      mrst_sync <= mrst_meta;
    end
  end
  assign rst_n = aresetn & mrst_sync; // RULE_19

  // Refusal: capture in background, whole run in foreground
  assign nack = BACKGROUND ? (|capturing) : (|busy); // RULE_10 RULE_16 RULE_13
  assign bank_ok = !bank_sel || (NUM_INST == 2); // RULE_11 RULE_14

  // Advertisement byte
  assign advert = {(NUM_INST == 2) ? CMB_ADV_TWO : CMB_ADV_ONE, BACKGROUND, 5'h00}; // RULE_15 RULE_20

  // Write decode over the page window
  assign wr_go = !awready && !wready && !bvalid;
  assign wr_word = aw_q[6:2];
  assign wr_cmd_pg = aw_q[CMB_WIN_BIT] && (page_sel == CMB_PAGE_CMD) && bank_ok; // RULE_01
  assign wr_epl_pg = aw_q[CMB_WIN_BIT] && (page_sel >= CMB_PAGE_EPL_FIRST) &&
                     (page_sel <= CMB_PAGE_EPL_LAST); // RULE_03
  assign lpl_old = local_payload_area[bank_sel][wr_word];
  assign wr_merged = merge(lpl_old, wdata_q, wstrb_q);
  assign lpl_wr_c = wr_cmd_pg && !busy[bank_sel] && (wr_word <= CMB_LPL_LAST_WORD); // RULE_02 RULE_23
  assign cmd_wr_c = lpl_wr_c && (wr_word == CMB_CMD_WORD);
  assign abort_c = wr_cmd_pg && busy[bank_sel] && (wr_word == CMB_CMD_WORD) &&
                   (wr_merged[15:0] == CMB_CMD_ABORT); // RULE_22
  assign epl_wr_c = wr_epl_pg && !(|busy); // RULE_23
  assign epl_wr_idx = {page_sel[3:0], wr_word};
  assign ctrl_wr_c = !aw_q[CMB_WIN_BIT] &&
                     ((aw_q == CMB_ADDR_PAGE_BANK) || (aw_q == CMB_ADDR_FLAGS) ||
                      (aw_q == CMB_ADDR_MASK) || (aw_q == CMB_ADDR_PRIV));
  assign wr_ok = !nack && (lpl_wr_c || abort_c || epl_wr_c || ctrl_wr_c);

  // Engine requests per bank
  assign start[0] = wr_go && wr_ok && cmd_wr_c && !bank_sel;
  assign start[1] = wr_go && wr_ok && cmd_wr_c && bank_sel;
  assign abort[0] = wr_go && wr_ok && abort_c && !bank_sel;
  assign abort[1] = wr_go && wr_ok && abort_c && bank_sel;
  assign flag_clr = (wr_go && wr_ok && aw_q == CMB_ADDR_FLAGS) ?
                    wdata_q[CMB_FLAG_LSB +: 2] : 2'b00;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      aw_q <= 12'h000;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_q <= awaddr;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      wready <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wready <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response; refused writes answer SLVERR so the host retries
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= CMB_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? CMB_RESP_OKAY : CMB_RESP_SLVERR; // RULE_18
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Page and bank select, masks, privilege
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      page_sel <= 8'h00;
      bank_sel <= 1'b0;
      mask <= 2'b00;
      priv <= 1'b1;
    end else if (ce && wr_go && wr_ok) begin
      if (aw_q == CMB_ADDR_PAGE_BANK) begin
        page_sel <= wdata_q[7:0];
        bank_sel <= wdata_q[CMB_BANK_BIT];
      end
      if (aw_q == CMB_ADDR_MASK) begin
        mask <= wdata_q[CMB_FLAG_LSB +: 2];
      end
      if (aw_q == CMB_ADDR_PRIV) begin
        priv <= wdata_q[0];
      end
    end
  end

  // Sticky flags; completion beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      flags <= 2'b00;
    end else if (ce) begin
      flags <= (flags & ~flag_clr) | done; // RULE_05 RULE_08
    end
  end

  // Interrupt pin low on any unmasked flag
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      module_interrupt_n <= 1'b1;
    end else if (ce) begin
      module_interrupt_n <= ~|(flags & ~mask); // RULE_24 RULE_08
    end
  end

  // Local payload; a busy bank keeps it
  always_ff @(posedge aclk) begin
    if (ce && wr_go && wr_ok && lpl_wr_c) begin
      local_payload_area[bank_sel][wr_word] <= wr_merged; // RULE_02 RULE_23
    end
  end

  // Extended payload, closed while busy
  always_ff @(posedge aclk) begin
    if (ce && wr_go && wr_ok && epl_wr_c) begin
      extended_payload_area[epl_wr_idx] <= merge(extended_payload_area[epl_wr_idx], wdata_q, wstrb_q); // RULE_03
    end
  end

  // Two instances, one per bank; the second idles when only one exists
  for (genvar b = 0; b < 2; b++) begin : g_inst
    cmb_engine u_engine (
      .aclk(aclk),
      .rst_n(rst_n),
      .ce(ce),
      .start(start[b]),
      .abort(abort[b]),
      .priv(priv),
      .cmd(wr_merged),
      .operand(local_payload_area[b][CMB_OPERAND_WORD]),
      .busy(busy[b]),
      .capturing(capturing[b]),
      .done(done[b]),
      .status(status[b]),
      .rsp(rsp[b])
    ); // RULE_12 RULE_14
  end

  // Read decode; status bytes sit outside the page window
  assign rd_go = !arready && !rvalid;
  assign rd_word = ar_q[6:2];
  assign epl_rd_idx = {page_sel[3:0], rd_word};
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rd_ok = 1'b0;
    if (nack) begin
      next_rd_ok = 1'b0; // RULE_16
    end else if (!ar_q[CMB_WIN_BIT]) begin
      next_rd_ok = 1'b1;
      case (ar_q)
        CMB_ADDR_PAGE_BANK: next_rdata = {23'h000000, bank_sel, page_sel};
        CMB_ADDR_FLAGS: next_rdata = {24'h000000, flags, 6'h00};
        CMB_ADDR_MASK: next_rdata = {24'h000000, mask, 6'h00};
        CMB_ADDR_STATUS0: next_rdata = {24'h000000, status[0]}; // RULE_04 RULE_17
        CMB_ADDR_STATUS1: next_rdata = {24'h000000, status[1]}; // RULE_04 RULE_17
        CMB_ADDR_ADVERT: next_rdata = {24'h000000, advert};
        CMB_ADDR_PRIV: next_rdata = {31'h00000000, priv};
        default: next_rd_ok = 1'b0;
      endcase
    end else if (page_sel == CMB_PAGE_CMD && bank_ok) begin
      next_rd_ok = 1'b1;
      // Top word returns the response
      next_rdata = (rd_word == CMB_RSP_WORD) ? rsp[bank_sel] : local_payload_area[bank_sel][rd_word];
    end else if (page_sel >= CMB_PAGE_EPL_FIRST && page_sel <= CMB_PAGE_EPL_LAST) begin
      next_rd_ok = 1'b1;
      next_rdata = extended_payload_area[epl_rd_idx];
    end
  end

  // Read address channel
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      ar_q <= 12'h000;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        ar_q <= araddr;
      end else if (rvalid && rready) begin
        arready <= 1'b1;
      end
    end
  end

  // Read data channel
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= CMB_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= next_rd_ok ? CMB_RESP_OKAY : CMB_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // cmb_top

/* File: cmb_top_checker.sv */
// Assertions on bus answers, map holes, interrupt pin
`timescale 1ns/10ps
module cmb_top_checker #(
  parameter int NUM_INST = cmb_pkg::CMB_NUM_INST,
  parameter logic BACKGROUND = cmb_pkg::CMB_BACKGROUND
) (
  // Clock, reset, enable
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // Write side
  input logic [cmb_pkg::CMB_AW-1:0] awaddr,
  input logic awvalid,
  input logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  input logic bready,
  // Read side
  input logic [cmb_pkg::CMB_AW-1:0] araddr,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  input logic rready,
  // Interrupt pin
  input logic module_interrupt_n
);
  import cmb_pkg::*;
  // Advertised bits 7:5 for this build
  localparam logic [2:0] ADV = {(NUM_INST == 2) ? CMB_ADV_TWO : CMB_ADV_ONE, BACKGROUND};
  // Unmapped control offset
  localparam logic [11:0] HOLE = 12'h01c;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Transfer openings
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_take |-> ##[1:2] bvalid)
    else $error("write not answered");
  AST_RD_ANSWER: assert property (rd_take |-> ##[1:2] rvalid)
    else $error("read not answered");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  // Address side closed until data taken
  AST_AR_BLOCK: assert property (rd_take |=> !arready until (rvalid && rready))
    else $error("read address reopened early");
  AST_HOLE: assert property (rd_take ##0 araddr == HOLE |-> ##[1:2] rresp == CMB_RESP_SLVERR)
    else $error("hole read not refused");
  AST_ADVERT: assert property (rd_take ##0 araddr == CMB_ADDR_ADVERT |-> ##[1:2] rdata[7:5] == ADV)
    else $error("advertisement wrong");
  // Masking both banks releases the pin
  AST_MASK_QUIET: assert property (wr_take ##0 (awaddr == CMB_ADDR_MASK && wstrb[0]
      && wdata[7:6] == 2'b11) |-> ##3 module_interrupt_n [*2])
    else $error("interrupt active while masked");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> module_interrupt_n && awready
      && arready && !bvalid && !rvalid)
    else $error("not idle after reset");
endmodule // cmb_top_checker

bind cmb_top cmb_top_checker #(.NUM_INST(NUM_INST), .BACKGROUND(BACKGROUND)) cmb_top_checker_i (.*);

/* File: cmb_host_model.sv */
// Host model: bus master and reset pin driver
`timescale 1ns/10ps
module cmb_host_model (
  // Clock
  input logic aclk,
  // Write side
  output logic [cmb_pkg::CMB_AW-1:0] awaddr,
  output logic awvalid,
  input logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  output logic bready,
  // Read side
  output logic [cmb_pkg::CMB_AW-1:0] araddr,
  output logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  output logic rready,
  // Module pin
  output logic module_reset_n
);
  import cmb_pkg::*;
  // Quiet bus at time zero; full words only
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
    module_reset_n = 1'b1;
  end
  // One write; address and data dropped as taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    module_command_block_engine_bench.hang("bresp");
  endtask
  // One read; data taken with rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    module_command_block_engine_bench.hang("rdata");
  endtask
  // Refused reads retried, bounded
  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    for (int n = 0; n < 20; n++) begin
      rd(a, d, r);
      if (r == CMB_RESP_OKAY) return;
    end
  endtask
  // Pin reset, held past the synchroniser
  task automatic pin_reset();
    @(posedge aclk);
    module_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    module_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
endmodule // cmb_host_model

/* File: module_command_block_engine_bench.sv */
// Self-checking command engine bench
`timescale 1ns/10ps
module module_command_block_engine_bench;
  import cmb_pkg::*;
  // Row: address, answer, data
  typedef struct {
    logic [11:0] a;
    logic [1:0] r;
    logic [31:0] d;
  } cmb_row_s;
  localparam logic [1:0] OK = CMB_RESP_OKAY;
  localparam logic [1:0] ER = CMB_RESP_SLVERR;
  logic aclk, aresetn, ce, module_reset_n, module_interrupt_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int errors, checks;
  // Reset values, one hole
  cmb_row_s regs [6] = '{'{CMB_ADDR_FLAGS, OK, 32'h0}, '{CMB_ADDR_STATUS0, OK, 32'h0},
    '{CMB_ADDR_STATUS1, OK, 32'h0}, '{CMB_ADDR_ADVERT, OK, 32'ha0},
    '{CMB_ADDR_PRIV, OK, 32'h1}, '{12'h01c, ER, 32'h0}};
  // Command word, final status
  logic [39:0] cmds [6] = '{40'hff00000001, 40'hfc00000342, 40'h37c8000044,
    40'h0000000045, 40'hfe00000147, 40'hfb00000401};

  cmb_top cmb_top_i (.*);
  cmb_host_model cmb_host_model_i (.*);

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e = OK);
    cmb_host_model_i.wr(a, v, r);
    chk("bresp", 34'(e), 34'(r));
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] v,
      input logic [1:0] e = OK);
    cmb_host_model_i.rdr(a, d, r);
    chk(n, {e, v}, {r, d});
  endtask
  // Poll status until not busy
  task automatic wait_done(input logic [11:0] a, input logic [7:0] e);
    for (int n = 0; n < 60; n++) begin
      cmb_host_model_i.rdr(a, d, r);
      if (d[7] === 1'b0) break;
    end
    if (d[7] !== 1'b0) hang("status");
    chk("status", {OK, 24'h0, e}, {r, d});
  endtask
  task automatic hang(input string n);
    errors++;
    $display("MISMATCH %s expected answer seen none", n);
    finish_test();
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rdc("reg", regs[i].a, regs[i].d, regs[i].r);
    wrc(CMB_ADDR_PAGE_BANK, 32'h9f);
    wrc(CMB_ADDR_MASK, 32'h0);
    foreach (cmds[i]) begin
      wrc(12'h400, cmds[i][39:8]);
      wait_done(CMB_ADDR_STATUS0, cmds[i][7:0]);
      wrc(CMB_ADDR_FLAGS, 32'h40);
    end
    $display("test table done, errors %0d", errors);
    // Echo, refusals, response, flag, pin
    wrc(12'h404, 32'h1234abcd);
    wrc(12'h400, 32'hfa040001);
    rdc("busy", CMB_ADDR_STATUS0, 32'(CMB_COMMAND_BUSY_FLAG));
    wrc(12'h404, 32'h0, ER);
    wrc(12'h400, 32'hff000000, ER);
    wait_done(CMB_ADDR_STATUS0, CMB_STS_OK);
    rdc("response", 12'h47c, 32'h1234abcd);
    rdc("payload", 12'h404, 32'h1234abcd);
    rdc("flags", CMB_ADDR_FLAGS, 32'h40);
    chk("irq", 34'h0, 34'(module_interrupt_n));
    wrc(CMB_ADDR_MASK, 32'hc0);
    repeat (2) @(posedge aclk);
    chk("irq_masked", 34'h1, 34'(module_interrupt_n));
    wrc(CMB_ADDR_MASK, 32'h0);
    wrc(CMB_ADDR_FLAGS, 32'h40);
    rdc("flags_clear", CMB_ADDR_FLAGS, 32'h0);
    chk("irq_clear", 34'h1, 34'(module_interrupt_n));
    // Abort while echo runs
    wrc(12'h400, 32'hfa040001);
    wrc(12'h400, 32'hfb000004);
    wait_done(CMB_ADDR_STATUS0, CMB_STS_ABORTED);
    $display("test echo_abort done, errors %0d", errors);
    // Both banks busy at once
    wrc(CMB_ADDR_PAGE_BANK, 32'h19f);
    wrc(12'h400, 32'hff000000);
    wrc(CMB_ADDR_PAGE_BANK, 32'h9f);
    wrc(12'h400, 32'hff000000);
    rdc("bank1_busy", CMB_ADDR_STATUS1, 32'(CMB_COMMAND_BUSY_FLAG));
    wait_done(CMB_ADDR_STATUS1, CMB_STS_OK);
    wait_done(CMB_ADDR_STATUS0, CMB_STS_OK);
    rdc("flags_both", CMB_ADDR_FLAGS, 32'hc0);
    wrc(CMB_ADDR_FLAGS, 32'hc0);
    // Privilege withdrawn: only abort may run
    wrc(CMB_ADDR_PRIV, 32'h0);
    wrc(12'h400, 32'hff000000);
    wait_done(CMB_ADDR_STATUS0, CMB_STS_ERR_PRIV);
    wrc(CMB_ADDR_PRIV, 32'h1);
    // Last extended word; page outside window
    wrc(CMB_ADDR_PAGE_BANK, 32'haf);
    wrc(12'h47c, 32'h5a5a0f0f);
    rdc("epl", 12'h47c, 32'h5a5a0f0f);
    wrc(CMB_ADDR_PAGE_BANK, 32'hb0);
    rdc("off_page", 12'h400, 32'h0, ER);
    // Pin reset clears a pending completion
    wrc(CMB_ADDR_PAGE_BANK, 32'h9f);
    wrc(12'h400, 32'hff000000);
    wait_done(CMB_ADDR_STATUS0, CMB_STS_OK);
    cmb_host_model_i.pin_reset();
    rdc("status_pin", CMB_ADDR_STATUS0, 32'h0);
    chk("irq_pin", 34'h1, 34'(module_interrupt_n));
    $display("test pages_pin done, errors %0d", errors);
    finish_test();
  end
endmodule // module_command_block_engine_bench
